// file: supervisor_pkg.sv
// Constants, types and timing figures shared by the reset supervisor and watchdog
// Notes on behaviour
// - Watchdog idle while main reset is asserted, except in its own fault hold
// - Watchdog fault: reset delay plus three ticks
// - Watchdog fault disables regulators in shutdown variant
// - Long timeout starts at main reset release
// - First kick starts closed and open windows
// - Kick inside closed window is a fault
// - Kick required before open window ends
// - Kick held high throughout a period faults
// - Kick high at release counts as kick
// - Watchdog timed by its own tick source
// - Main rail outside window asserts main reset
// - Above 2 V, global faults assert main reset
// - Boost window, battery, thermal faults assert boost reset
// - External feedback outside window asserts its reset
// - Release delay 2475/current ms, else immediate
// - Cap pin low plus sync high enters debug
// - Debug ends when either condition drops
// - Cap pin low without sync high faults
package supervisor_pkg;

    // System clock
    localparam int unsigned CLK_FREQ_HZ     = 25_000_000;
    localparam int unsigned MS_PER_S        = 1000;
    localparam int unsigned CLK_CYCLES_MS   = CLK_FREQ_HZ / MS_PER_S;

    // Reset delay law: delay in ms = DELAY_NUM_MS_UA / current in uA
    localparam int unsigned DELAY_NUM_MS_UA = 2475;
    localparam int unsigned DELAY_MAX_UA    = 500;
    localparam int unsigned CUR_W           = 10;

    // Watchdog timing, counted in watchdog oscillator ticks
    localparam int unsigned WD_EXTRA_TICKS  = 3;
    localparam int unsigned WD_TICK_DIV     = 25;
    localparam int unsigned WD_LONG_TICKS   = 20_000;
    localparam int unsigned WD_CLOSED_TICKS = 100;
    localparam int unsigned WD_OPEN_TICKS   = 1_000;
    localparam int unsigned WD_CNT_W        = 24;
    localparam int unsigned DLY_W           = 32;

    // Analog monitor results, one bit per comparator
    typedef struct packed {
        logic main_over;
        logic main_under;
        logic main_above_2v;
        logic boost_over;
        logic boost_under;
        logic ext_over;
        logic ext_under;
        logic batt_over;
        logic batt_under;
        logic thermal_shutdown_fault;
    } monitor_s;

    // Current into each reset pin, in uA
    typedef struct packed {
        logic [CUR_W-1:0] main_ua;
        logic [CUR_W-1:0] boost_ua;
        logic [CUR_W-1:0] ext_ua;
    } delay_cfg_s;

    // Watchdog phases
    typedef enum logic [4:0] {
        WD_IDLE   = 5'b00001,
        WD_LONG   = 5'b00010,
        WD_CLOSED = 5'b00100,
        WD_OPEN   = 5'b01000,
        WD_HOLD   = 5'b10000
    } wd_state_e;

endpackage : supervisor_pkg

// file: kick_sync.sv
// Two-stage synchroniser with rising edge detector for the kick input
`timescale 1ns/1ps
`default_nettype none
module kick_sync (
    input  wire logic clock_i,
    input  wire logic reset_n_i,
    input  wire logic async_i,
    output var  logic level_o,
    output var  logic rise_o
);
    logic meta_q;
    logic level_q;
    logic prev_q;
    logic rise_q;

    // Only level_q reads the first stage
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q  <= 1'b0;
            level_q <= 1'b0;
            prev_q  <= 1'b0;
            rise_q  <= 1'b0;
        end else begin
            meta_q  <= async_i;
            level_q <= meta_q;
            prev_q  <= level_q;
            rise_q  <= level_q & ~prev_q;
        end
    end

    assign level_o = prev_q;
    assign rise_o  = rise_q;
endmodule : kick_sync
`default_nettype wire

// file: reset_delay.sv
// Holds one reset asserted while its cause stands and for a delay after it clears
`timescale 1ns/1ps
`default_nettype none
module reset_delay
    import supervisor_pkg::*;
(
    input  wire logic             clock_i,
    input  wire logic             reset_n_i,
    input  wire logic             cause_i,
    input  wire logic [DLY_W-1:0] delay_cycles_i,
    output var  logic             active_o
);
    logic [DLY_W-1:0] cnt_q;

    // Restart on every cause cycle; release after delay_cycles_i + 1 quiet cycles
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_q    <= '0;
            active_o <= 1'b1;
        end else if (cause_i) begin
            cnt_q    <= '0;
            active_o <= 1'b1;
        end else if (active_o) begin
            if (cnt_q >= delay_cycles_i) begin
                active_o <= 1'b0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule : reset_delay
`default_nettype wire

// file: supervisor_top.sv
// Window watchdog and reset supervisor with three open-drain reset outputs
`timescale 1ns/1ps
`default_nettype none
module supervisor_top
    import supervisor_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS    = CLK_CYCLES_MS,
    parameter int unsigned TICK_DIV         = WD_TICK_DIV,
    parameter int unsigned LONG_TICKS       = WD_LONG_TICKS,
    parameter int unsigned CLOSED_TICKS     = WD_CLOSED_TICKS,
    parameter int unsigned OPEN_TICKS       = WD_OPEN_TICKS,
    parameter bit          SHUTDOWN_ON_WD   = 1'b0
) (
    input  wire logic       clock_i,
    input  wire logic       reset_n_i,
    input  wire logic       enable_i,
    input  wire monitor_s   monitor_i,
    input  wire delay_cfg_s delay_cfg_i,
    input  wire logic       kick_input_i,
    input  wire logic       watchdog_cap_pin_low_i,
    input  wire logic       sync_clock_input_high_i,
    output var  logic       main_reset_out_o,
    output var  logic       main_reset_out_oe_o,
    output var  logic       boost_reset_out_o,
    output var  logic       boost_reset_out_oe_o,
    output var  logic       ext_monitor_reset_out_o,
    output var  logic       ext_monitor_reset_out_oe_o,
    output var  logic       regulators_disable_o,
    output var  logic       debug_mode_o,
    output var  logic       watchdog_fault_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Release delay in clock cycles from pin current; zero means power good
    function automatic logic [DLY_W-1:0] delay_cycles(input logic [CUR_W-1:0] ua);
        logic [63:0] num;
        num = 64'(DELAY_NUM_MS_UA) * 64'(CYCLES_PER_MS);
        if (ua >= CUR_W'(DELAY_MAX_UA)) begin
            delay_cycles = '0;
        end else if (ua == '0) begin
            delay_cycles = DLY_W'(num);
        end else begin
            delay_cycles = DLY_W'(num / 64'(ua));
        end
    endfunction : delay_cycles

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic                  kick_level;
    logic                  kick_rise;
    logic                  main_active;
    logic                  boost_active;
    logic                  ext_active;
    logic                  main_active_q;
    logic                  main_rise;
    logic                  global_fault;
    logic                  main_cause;
    logic                  boost_cause;
    logic                  ext_cause;
    logic                  cap_fault;
    logic                  wd_fault_pulse;
    logic [DLY_W-1:0]      main_dly_q;
    logic [DLY_W-1:0]      boost_dly_q;
    logic [DLY_W-1:0]      ext_dly_q;
    logic [15:0]           tick_cnt_q;
    logic                  tick_q;
    logic                  kick_rise_q;
    logic                  kick_low_seen_q;
    wd_state_e             wd_state_q;
    wd_state_e             wd_state_d;
    logic [WD_CNT_W-1:0]   wd_cnt_q;
    logic [1:0]            hold_cnt_q;
    logic                  wd_fault_d;

    ////////////////////////////////////////////////////////////////////////////
    // Kick synchroniser

    kick_sync u_kick_sync (
        .clock_i   (clock_i),
        .reset_n_i (reset_n_i),
        .async_i   (kick_input_i),
        .level_o   (kick_level),
        .rise_o    (kick_rise)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Debug mode and cap pin fault

    // Debug lasts only while both pin conditions hold
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            debug_mode_o <= 1'b0;
        end else begin
            debug_mode_o <= watchdog_cap_pin_low_i & sync_clock_input_high_i;
        end
    end

    assign cap_fault = watchdog_cap_pin_low_i & ~sync_clock_input_high_i;

    ////////////////////////////////////////////////////////////////////////////
    // Reset causes

    assign global_fault = monitor_i.batt_over | monitor_i.batt_under | monitor_i.thermal_shutdown_fault;

    // Window monitor always counts; the rest once the main rail is alive
    assign main_cause = monitor_i.main_over | monitor_i.main_under
                      | (monitor_i.main_above_2v
                         & (~enable_i | global_fault | (wd_state_q == WD_HOLD) | cap_fault));

    assign boost_cause = monitor_i.boost_over | monitor_i.boost_under | global_fault;
    assign ext_cause   = monitor_i.ext_over | monitor_i.ext_under;

    // Per-output delays from the configured currents
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            main_dly_q  <= '0;
            boost_dly_q <= '0;
            ext_dly_q   <= '0;
        end else begin
            main_dly_q  <= delay_cycles(delay_cfg_i.main_ua);
            boost_dly_q <= delay_cycles(delay_cfg_i.boost_ua);
            ext_dly_q   <= delay_cycles(delay_cfg_i.ext_ua);
        end
    end

    reset_delay u_main_delay (
        .clock_i        (clock_i),
        .reset_n_i      (reset_n_i),
        .cause_i        (main_cause),
        .delay_cycles_i (main_dly_q),
        .active_o       (main_active)
    );

    reset_delay u_boost_delay (
        .clock_i        (clock_i),
        .reset_n_i      (reset_n_i),
        .cause_i        (boost_cause),
        .delay_cycles_i (boost_dly_q),
        .active_o       (boost_active)
    );

    reset_delay u_ext_delay (
        .clock_i        (clock_i),
        .reset_n_i      (reset_n_i),
        .cause_i        (ext_cause),
        .delay_cycles_i (ext_dly_q),
        .active_o       (ext_active)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain pins: data low, enable high while pulling the pin low

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            main_reset_out_o           <= 1'b0;
            boost_reset_out_o          <= 1'b0;
            ext_monitor_reset_out_o    <= 1'b0;
            main_reset_out_oe_o        <= 1'b1;
            boost_reset_out_oe_o       <= 1'b1;
            ext_monitor_reset_out_oe_o <= 1'b1;
        end else begin
            main_reset_out_o           <= 1'b0;
            boost_reset_out_o          <= 1'b0;
            ext_monitor_reset_out_o    <= 1'b0;
            main_reset_out_oe_o        <= main_active;
            boost_reset_out_oe_o       <= boost_active;
            ext_monitor_reset_out_oe_o <= ext_active;
        end
    end

    // Main reset release edge
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            main_active_q <= 1'b1;
        end else begin
            main_active_q <= main_active;
        end
    end

    assign main_rise = main_active_q & ~main_active;

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog oscillator tick, free running and separate from regulator timing

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else if (tick_cnt_q >= 16'(TICK_DIV - 1)) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
            tick_q     <= 1'b0;
        end
    end

    // Kick edges are caught at clock rate and consumed on the next tick
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            kick_rise_q <= 1'b0;
        end else if (main_rise) begin
            kick_rise_q <= 1'b0; // Edge before release is the level kick
        end else if (kick_rise) begin
            kick_rise_q <= 1'b1;
        end else if (tick_q) begin
            kick_rise_q <= 1'b0;
        end
    end

    // Records whether the kick went low in the running period
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            kick_low_seen_q <= 1'b0;
        end else if (wd_state_q != wd_state_d) begin
            kick_low_seen_q <= ~kick_level;
        end else if (~kick_level) begin
            kick_low_seen_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog state machine

    always_comb begin
        wd_state_d = wd_state_q;
        wd_fault_d = 1'b0;
        case (wd_state_q)
            WD_IDLE: begin
                if (main_rise && !debug_mode_o) begin
                    if (kick_level) begin
                        wd_state_d = WD_CLOSED;
                    end else begin
                        wd_state_d = WD_LONG;
                    end
                end
            end
            WD_LONG: begin
                if (tick_q && kick_rise_q) begin
                    wd_state_d = WD_CLOSED;
                end else if (tick_q && wd_cnt_q >= WD_CNT_W'(LONG_TICKS - 1)) begin
                    wd_fault_d = 1'b1;
                end
            end
            WD_CLOSED: begin
                if (tick_q && kick_rise_q) begin
                    wd_fault_d = 1'b1;
                end else if (tick_q && wd_cnt_q >= WD_CNT_W'(CLOSED_TICKS - 1)) begin
                    wd_state_d = WD_OPEN;
                end
            end
            WD_OPEN: begin
                if (tick_q && kick_rise_q) begin
                    wd_state_d = WD_CLOSED;
                end else if (tick_q && wd_cnt_q >= WD_CNT_W'(OPEN_TICKS - 1)) begin
                    wd_fault_d = 1'b1;
                end
            end
            WD_HOLD: begin
                if (tick_q && hold_cnt_q >= 2'(WD_EXTRA_TICKS - 1)) begin
                    wd_state_d = WD_IDLE;
                end
            end
            default: begin
                wd_state_d = WD_IDLE;
            end
        endcase
        if (wd_fault_d) begin
            wd_state_d = WD_HOLD;
        end
        // Main reset asserted by other causes or debug stops the watchdog
        if (wd_state_q != WD_HOLD && (main_active || debug_mode_o)) begin
            wd_state_d = WD_IDLE;
            wd_fault_d = 1'b0;
        end
    end

    assign wd_fault_pulse = wd_fault_d;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wd_state_q <= WD_IDLE;
        end else begin
            wd_state_q <= wd_state_d;
        end
    end

    // Period counter in ticks, restarted on every phase change except closed to open
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wd_cnt_q <= '0;
        end else if (wd_state_d != wd_state_q && wd_state_d != WD_OPEN) begin
            wd_cnt_q <= '0;
        end else if (tick_q) begin
            wd_cnt_q <= wd_cnt_q + 1'b1;
        end
    end

    // Extra ticks of hold after a watchdog fault
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hold_cnt_q <= '0;
        end else if (wd_state_q != WD_HOLD) begin
            hold_cnt_q <= '0;
        end else if (tick_q) begin
            hold_cnt_q <= hold_cnt_q + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fault reporting and regulator shutdown

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            watchdog_fault_o <= 1'b0;
        end else begin
            watchdog_fault_o <= wd_fault_pulse;
        end
    end

    // Shutdown variant keeps switchers off until the main reset releases
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            regulators_disable_o <= 1'b0;
        end else if (SHUTDOWN_ON_WD && wd_fault_pulse) begin
            regulators_disable_o <= 1'b1;
        end else if (main_rise) begin
            regulators_disable_o <= 1'b0;
        end
    end

endmodule : supervisor_top
`default_nettype wire

// file: supervisor_chk.sv
// Concurrent checks on the ports of the supervisor top
`timescale 1ns/1ps
`default_nettype none
module supervisor_chk
    import supervisor_pkg::*;
#(
    parameter bit SHUTDOWN_ON_WD = 1'b0
) (
    input wire logic       clock_i,
    input wire logic       reset_n_i,
    input wire logic       enable_i,
    input wire monitor_s   monitor_i,
    input wire logic       watchdog_cap_pin_low_i,
    input wire logic       sync_clock_input_high_i,
    input wire logic       main_reset_out_oe_o,
    input wire logic       boost_reset_out_oe_o,
    input wire logic       ext_monitor_reset_out_oe_o,
    input wire logic       regulators_disable_o,
    input wire logic       debug_mode_o,
    input wire logic       watchdog_fault_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoded main rail window, global fault and debug pin pair conditions
    logic main_win, glob, pair;
    assign main_win = monitor_i.main_over | monitor_i.main_under;
    assign glob     = monitor_i.batt_over | monitor_i.batt_under | monitor_i.thermal_shutdown_fault;
    assign pair     = watchdog_cap_pin_low_i & sync_clock_input_high_i;

    ////////////////////////////////////////////////////////////////////////////////
    a_main_window: assert property (main_win |-> ##[1:2] main_reset_out_oe_o)
        else $error("rail fault missed");
    a_main_global: assert property (monitor_i.main_above_2v && (!enable_i || glob) |-> ##[1:2] main_reset_out_oe_o)
        else $error("global fault missed");
    a_cap_fault: assert property (monitor_i.main_above_2v && watchdog_cap_pin_low_i && !sync_clock_input_high_i
        |-> ##[1:2] main_reset_out_oe_o)
        else $error("cap fault missed");
    a_boost_cause: assert property (monitor_i.boost_over || monitor_i.boost_under || glob
        |-> ##[1:2] boost_reset_out_oe_o)
        else $error("boost cause missed");
    a_ext_window: assert property (monitor_i.ext_over || monitor_i.ext_under |-> ##[1:2] ext_monitor_reset_out_oe_o)
        else $error("ext fault missed");
    a_fault_hold: assert property (watchdog_fault_o |-> ##[1:2] main_reset_out_oe_o [*8])
        else $error("fault hold short");
    a_regs_off: assert property (watchdog_fault_o |-> ##[1:2] (regulators_disable_o == SHUTDOWN_ON_WD))
        else $error("regulator disable wrong");
    a_debug_enter: assert property (pair |-> ##[1:3] debug_mode_o)
        else $error("debug mode not entered");
    a_debug_exit: assert property (debug_mode_o && !pair |-> ##[1:3] !debug_mode_o)
        else $error("debug mode not left");
    a_debug_quiet: assert property (debug_mode_o && $past(debug_mode_o) |-> !watchdog_fault_o)
        else $error("fault in debug");
    a_idle_rail: assert property (main_win && $past(main_win) && $past(main_win, 2) && $past(main_win, 3)
        |-> !watchdog_fault_o)
        else $error("fault while idle");
endmodule : supervisor_chk
`default_nettype wire

// file: kick_host.sv
// Microcontroller model that sends watchdog kick pulses
`timescale 1ns/1ps
`default_nettype none
module kick_host (
    input  wire logic        clock_i,
    input  wire logic        run_i,
    input  wire logic        hold_i,
    input  wire logic [15:0] period_i,
    output var  logic        kick_o
);
    logic [15:0] cnt_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Period counter, restarted while the host is stopped
    always_ff @(posedge clock_i) begin
        if (!run_i) begin
            cnt_q <= 16'h0000;
        end else begin
            cnt_q <= (cnt_q + 16'h0001 >= period_i) ? 16'h0000 : cnt_q + 16'h0001;
        end
    end

    // Two-cycle pulse at each period start, or a stuck level when stopped
    always_ff @(posedge clock_i) begin
        kick_o <= run_i ? (cnt_q < 16'h0002) : hold_i;
    end
endmodule : kick_host
`default_nettype wire

// file: tb_window_watchdog_reset_supervisor.sv
// Self-checking bench for the window watchdog and reset supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_window_watchdog_reset_supervisor;
    import supervisor_pkg::*;
    localparam int TDIV = 4;
    localparam int LONG = 40;
    localparam int CLS  = 4;
    localparam int OPN  = 16;
    localparam int CPMS = 10;
    localparam int DLY  = 2475 * CPMS / 495;

    logic        clk      = 1'b0;
    logic        rst_n    = 1'b0;
    logic        en       = 1'b1;
    monitor_s    mon      = 10'h080;
    delay_cfg_s  cfg      = {3{10'h3e8}};
    logic        cap_low  = 1'b0;
    logic        sync_hi  = 1'b0;
    logic        h_run    = 1'b0;
    logic        h_hold   = 1'b0;
    logic [15:0] h_per    = 16'h0028;
    logic        kick, m_od, m_oe, b_od, b_oe, e_od, e_oe, regs_off, dbg, wd_fault;
    int          n_mismatch, cmp_count, n_fault;

    always #20 clk = ~clk;

    supervisor_top #(.CYCLES_PER_MS(CPMS), .TICK_DIV(TDIV), .LONG_TICKS(LONG), .CLOSED_TICKS(CLS),
        .OPEN_TICKS(OPN), .SHUTDOWN_ON_WD(1'b1)) DUT (
        .clock_i(clk), .reset_n_i(rst_n), .enable_i(en), .monitor_i(mon), .delay_cfg_i(cfg),
        .kick_input_i(kick), .watchdog_cap_pin_low_i(cap_low), .sync_clock_input_high_i(sync_hi),
        .main_reset_out_o(m_od), .main_reset_out_oe_o(m_oe), .boost_reset_out_o(b_od),
        .boost_reset_out_oe_o(b_oe), .ext_monitor_reset_out_o(e_od), .ext_monitor_reset_out_oe_o(e_oe),
        .regulators_disable_o(regs_off), .debug_mode_o(dbg), .watchdog_fault_o(wd_fault));

    kick_host host (.clock_i(clk), .run_i(h_run), .hold_i(h_hold), .period_i(h_per), .kick_o(kick));

    // Fault pulses counted away from the launching edge
    always @(negedge clk) if (wd_fault === 1'b1) n_fault++;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wait_oe_low(output int n);
        n = 0;
        while (m_oe !== 1'b0 && n < 400) begin
            cyc(1);
            n++;
        end
    endtask : wait_oe_low

    task automatic wait_fault(output int n);
        int b;
        b = n_fault;
        n = 0;
        while (n_fault == b && n < 400) begin
            cyc(1);
            n++;
        end
    endtask : wait_fault

    // Short main rail dip, then wait for the main reset to release
    task automatic rel;
        int n;
        @(posedge clk) mon.main_under <= 1'b1;
        cyc(3);
        @(posedge clk) mon.main_under <= 1'b0;
        wait_oe_low(n);
    endtask : rel

    task automatic kick_run(input logic [15:0] per, output int n);
        @(posedge clk) h_run <= 1'b0;
        rel();
        @(posedge clk) begin h_per <= per; h_run <= 1'b1; end
        wait_fault(n);
    endtask : kick_run

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_rails;
        logic [9:0] em, eb, ee;
        em = 10'h307;
        eb = 10'h067;
        ee = 10'h018;
        for (int i = 0; i < 10; i++) begin
            if (i == 7) continue;
            @(posedge clk) mon <= monitor_s'(10'h080 | (10'h001 << i));
            cyc(3);
            chk("main_oe", em[i], m_oe);
            chk("boost_oe", eb[i], b_oe);
            chk("ext_oe", ee[i], e_oe);
            @(posedge clk) mon <= 10'h080;
            cyc(8);
            chk("oe_clear", 3'h0, {m_oe, b_oe, e_oe});
        end
        chk("od_data", 3'h0, {m_od, b_od, e_od});
        @(posedge clk) mon <= 10'h004;
        cyc(3);
        chk("main_oe_low_rail", 1'b0, m_oe);
        @(posedge clk) begin mon <= 10'h080; en <= 1'b0; end
        cyc(3);
        chk("main_oe_enable", 1'b1, m_oe);
        @(posedge clk) en <= 1'b1;
        cyc(8);
        $display("t_rails done");
    endtask : t_rails

    task automatic t_delay;
        int n;
        @(posedge clk) cfg.main_ua <= 10'h1ef;
        cyc(2);
        rel();
        @(posedge clk) mon.main_under <= 1'b1;
        cyc(3);
        @(posedge clk) mon.main_under <= 1'b0;
        wait_oe_low(n);
        chk("delay_span", 1'b1, n >= DLY && n <= DLY + 6);
        @(posedge clk) cfg.main_ua <= 10'h3e8;
        cyc(2);
        $display("t_delay done");
    endtask : t_delay

    task automatic t_kicks;
        int b;
        @(posedge clk) begin h_per <= 16'h0028; h_run <= 1'b1; end
        rel();
        b = n_fault;
        cyc(800);
        chk("good_kick_faults", 0, n_fault - b);
        chk("good_kick_oe", 1'b0, m_oe);
        $display("t_kicks done");
    endtask : t_kicks

    task automatic t_long;
        int n;
        @(posedge clk) h_run <= 1'b0;
        rel();
        wait_fault(n);
        chk("long_span", 1'b1, n >= LONG * TDIV - 8 && n <= LONG * TDIV + 8);
        cyc(2);
        chk("fault_oe", 1'b1, m_oe);
        chk("regs_off", 1'b1, regs_off);
        wait_oe_low(n);
        chk("fault_hold", 1'b1, n >= 3 * TDIV - 4 && n <= 3 * TDIV + 8);
        cyc(2);
        chk("regs_back_on", 1'b0, regs_off);
        $display("t_long done");
    endtask : t_long

    task automatic t_closed;
        int n;
        kick_run(16'h0008, n);
        chk("closed_kick_span", 1'b1, n >= 4 && n <= CLS * TDIV + 8);
        $display("t_closed done");
    endtask : t_closed

    task automatic t_late;
        int n;
        kick_run(16'h0064, n);
        chk("late_kick_span", 1'b1, n >= OPN * TDIV - 4 && n <= OPN * TDIV + 16);
        $display("t_late done");
    endtask : t_late

    task automatic t_held;
        int n;
        @(posedge clk) begin h_run <= 1'b0; h_hold <= 1'b1; end
        rel();
        wait_fault(n);
        chk("held_span", 1'b1, n >= OPN * TDIV - 4 && n <= OPN * TDIV + 16);
        @(posedge clk) h_hold <= 1'b0;
        $display("t_held done");
    endtask : t_held

    task automatic t_debug;
        int b;
        @(posedge clk) begin cap_low <= 1'b1; sync_hi <= 1'b1; end
        cyc(4);
        chk("debug_on", 1'b1, dbg);
        rel();
        b = n_fault;
        cyc(LONG * TDIV + 40);
        chk("debug_faults", 0, n_fault - b);
        @(posedge clk) sync_hi <= 1'b0;
        cyc(4);
        chk("debug_off", 1'b0, dbg);
        chk("cap_fault_oe", 1'b1, m_oe);
        @(posedge clk) cap_low <= 1'b0;
        cyc(4);
        $display("t_debug done");
    endtask : t_debug

    task automatic t_idle;
        int b;
        @(posedge clk) mon.main_under <= 1'b1;
        cyc(4);
        b = n_fault;
        cyc(LONG * TDIV + 90);
        chk("idle_faults", 0, n_fault - b);
        @(posedge clk) mon.main_under <= 1'b0;
        cyc(4);
        $display("t_idle done");
    endtask : t_idle

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk) h_run <= 1'b1;
        cyc(20);
        t_rails();
        t_delay();
        t_kicks();
        t_long();
        t_closed();
        t_late();
        t_held();
        t_debug();
        t_idle();
        tally_and_finish();
    end

    // Hang guard
    initial begin
        #(40 * 6000);
        n_mismatch++;
        tally_and_finish();
    end
endmodule : tb_window_watchdog_reset_supervisor

bind supervisor_top supervisor_chk #(.SHUTDOWN_ON_WD(SHUTDOWN_ON_WD)) u_chk (.*);
`default_nettype wire
